// [design/sarf_formatter.sv]
// sarf_formatter: codes, justifies and averages sar conversion results.
// assumes converter samples arrive on ref_clk and software uses axi4-lite.
`timescale 1ns/1ps
module sarf_formatter import sarf_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  // converter side
  input wire sarf_sample_t smp,
  output sarf_result_t res,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // register state and its next value
  sarf_state_t st_reg;
  sarf_state_t st_next;

  // everything the block remembers lives in one packed struct:
  // bus handshake flags, configuration, per-channel results,
  // fresh flags and the averaging accumulator.
  // one combinational process computes the whole next state and
  // one clocked process registers it, so every output is a flop.
  // the converter sample arrives on ref_clk already, so it is
  // used directly with no synchroniser in front of it.

  // merge write data into an old word by byte enables
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction : strb_merge

  // address to channel slot within a block, 4'hf when outside it
  function automatic logic [3:0] slot(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] d;
    d = addr - base;
    if (addr >= base && d[1:0] == 2'h0 && d[7:2] < 6'(SARF_NCHAN)) begin
      return d[5:2];
    end
    return 4'hf;
  endfunction : slot

  // coding choice per channel kind:
  // - differential channels follow the differential flag
  // - ground-referenced single-ended is always signed, since a
  //   slightly negative input must not wrap to a large number
  // - external negative input behaves as a differential pair
  // - reference-referenced single-ended follows its own flag
  // signed coding for a channel: diff, external negative, or forced for ground
  function automatic logic is_signed(input sarf_gcfg_t g, input logic diff);
    if (diff) begin
      return g.diff_signed; // R01
    end
    case (g.se_neg)
      SARF_NEG_VSS: return 1'b1; // R04
      SARF_NEG_EXT: return g.diff_signed; // R11
      default: return g.se_signed; // R02
    endcase
  endfunction : is_signed

  // n-bit code taken from the top of the 12-bit conversion
  function automatic logic [11:0] trim(input logic [11:0] code, input logic alternate_resolution_select,
                                       input logic ten);
    if (!alternate_resolution_select) begin
      return code;
    end
    if (ten) begin
      return {2'h0, code[11:2]}; // R09
    end
    return {4'h0, code[11:4]}; // R09
  endfunction : trim

  // numeric value of a sample, signed view where coding is signed
  function automatic logic signed [23:0] value(input logic [11:0] code, input logic alternate_resolution_select,
                                               input logic ten, input logic sgn);
    logic [11:0] t;
    t = trim(code, alternate_resolution_select, ten);
    if (!sgn) begin
      return {12'h000, t};
    end
    // offset binary to two's complement: subtract the midscale
    if (!alternate_resolution_select) begin
      return 24'(signed'({12'h000, t})) - 24'sh000800; // R03 R05
    end
    if (ten) begin
      return 24'(signed'({12'h000, t})) - 24'sh000200;
    end
    return 24'(signed'({12'h000, t})) - 24'sh000080;
  endfunction : value

  // place a single conversion into the 16-bit word
  function automatic logic [15:0] place(input logic [11:0] code, input logic alternate_resolution_select,
                                        input logic ten, input logic sgn, input logic left);
    logic [11:0] t;
    logic [23:0] v;
    t = trim(code, alternate_resolution_select, ten);
    v = value(code, alternate_resolution_select, ten, sgn);
    if (left) begin
      // msb at bit 15, low bits zero
      if (!alternate_resolution_select) begin
        return {(sgn ? ~t[11] : t[11]), t[10:0], 4'h0}; // R06 R14
      end
      if (ten) begin
        return {(sgn ? ~t[9] : t[9]), t[8:0], 6'h00}; // R06 R14
      end
      return {(sgn ? ~t[7] : t[7]), t[6:0], 8'h00}; // R06 R14
    end
    if (sgn) begin
      return v[15:0]; // R07 R03
    end
    return {4'h0, t}; // R06 R14
  endfunction : place

  // the accumulator is 24 bits wide so that 256 full-scale
  // samples cannot overflow it; the fit step below drops low
  // bits instead of clamping, so the sum keeps its sign and
  // relative size when it outgrows the result word.
  // the loop is bounded at eight halvings, which covers the
  // largest sum the accumulator can hold.
  // shrink an accumulated sum until it fits a 16-bit word
  function automatic logic [15:0] fit16(input logic signed [23:0] s, input logic sgn);
    logic signed [23:0] a;
    a = s;
    for (int i = 0; i < 8; i++) begin
      if (sgn && (a > 24'sh007fff || a < -24'sh008000)) begin
        a = a >>> 1; // R13
      end else if (!sgn && a > 24'sh00ffff) begin
        a = a >>> 1; // R13
      end
    end
    return a[15:0]; // R12
  endfunction : fit16

  // next-state logic: bus slave, configuration, formatting, averaging
  always_comb begin
    logic [3:0] ws;
    logic [3:0] rs;
    logic [31:0] old;
    sarf_ccfg_t cc;
    logic sgn;
    logic [8:0] nsamp;
    logic signed [23:0] sum;
    logic [SARF_NCHAN-1:0] clr;
    st_next = st_reg;
    ws = 4'hf;
    rs = 4'hf;
    old = 32'h0;
    cc = SARF_CCFG_RST;
    sgn = 1'b0;
    nsamp = 9'h0;
    sum = 24'sh0;
    clr = '0;
    st_next.res.valid = 1'b0;

    // response channels drop once taken
    if (st_reg.bvalid && s_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && s_rready) begin
      st_next.rvalid = 1'b0;
    end

    // capture address and data in either order
    if (s_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_awaddr;
    end
    if (s_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_wdata;
      st_next.w_strb = s_wstrb;
    end

    // a write lands only while no response is pending, so a
    // second write buffered behind an untaken response waits
    // and cannot overwrite the response code of the first.
    // byte enables are merged into the old word so that a
    // partial write leaves the other fields untouched.
    // perform a write once both halves are held
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = SARF_RESP_OKAY;
      ws = slot(st_reg.aw_addr, SARF_OFS_CHCFG);
      if (st_reg.aw_addr == SARF_OFS_GLOBAL) begin
        old = 32'({st_reg.gcfg.se_neg, 1'b0, st_reg.gcfg.avg_log, st_reg.gcfg.alt_ten,
                   st_reg.gcfg.left_just, st_reg.gcfg.se_signed, st_reg.gcfg.diff_signed});
        old = strb_merge(old, st_reg.w_data, st_reg.w_strb);
        st_next.gcfg.diff_signed = old[SARF_GB_DIFF_SIGNED];
        st_next.gcfg.se_signed = old[SARF_GB_SE_SIGNED];
        st_next.gcfg.left_just = old[SARF_GB_LEFT_JUST];
        st_next.gcfg.alt_ten = old[SARF_GB_ALT_TEN]; // R09
        st_next.gcfg.avg_log = old[SARF_GB_AVG_LOG +: 3]; // R08
        // unused selection code falls back to the vss case
        st_next.gcfg.se_neg = (old[SARF_GB_SE_NEG +: 2] == 2'h3) ? SARF_NEG_VSS :
                              sarf_neg_t'(old[SARF_GB_SE_NEG +: 2]);
      end else if (ws != 4'hf) begin
        old = strb_merge(32'(st_reg.ccfg[ws]), st_reg.w_data, st_reg.w_strb);
        st_next.ccfg[ws] = old[2:0]; // R10
      end else if (st_reg.aw_addr != SARF_OFS_STATUS &&
                   slot(st_reg.aw_addr, SARF_OFS_RESULT) == 4'hf) begin
        st_next.bresp = SARF_RESP_SLVERR; // unmapped
      end
    end

    // read: answer the cycle after the address is taken
    if (s_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = SARF_RESP_OKAY;
      st_next.rdata = 32'h0;
      rs = slot(s_araddr, SARF_OFS_RESULT);
      ws = slot(s_araddr, SARF_OFS_CHCFG);
      if (s_araddr == SARF_OFS_GLOBAL) begin
        st_next.rdata = 32'({st_reg.gcfg.se_neg, 1'b0, st_reg.gcfg.avg_log,
                             st_reg.gcfg.alt_ten, st_reg.gcfg.left_just,
                             st_reg.gcfg.se_signed, st_reg.gcfg.diff_signed});
      end else if (s_araddr == SARF_OFS_STATUS) begin
        st_next.rdata = 32'(st_reg.fresh);
        st_next.rdata[SARF_SB_AVG_BUSY] = st_reg.acc_busy;
      end else if (ws != 4'hf) begin
        st_next.rdata = 32'(st_reg.ccfg[ws]);
      end else if (rs != 4'hf) begin
        st_next.rdata = {16'h0000, st_reg.results[rs]}; // R14
        clr[rs] = 1'b1; // reading consumes the fresh flag
      end else begin
        st_next.rresp = SARF_RESP_SLVERR; // unmapped
      end
    end

    // conversion path:
    // - channel numbers beyond the last channel are ignored
    // - averaged channels sum samples in the chosen coding and
    //   publish once the global count is reached
    // - a sample on another averaged channel restarts the sum, so a
    //   sequencer that leaves a channel early loses its samples
    // - plain channels are formatted and published at once
    // incoming conversion
    if (smp.valid && smp.chan < 4'(SARF_NCHAN)) begin
      cc = sarf_ccfg_t'(st_reg.ccfg[smp.chan]);
      sgn = is_signed(st_reg.gcfg, cc.diff);
      nsamp = 9'h002 << st_reg.gcfg.avg_log; // R08
      if (cc.avg) begin
        // a new channel restarts the sum
        if (st_reg.acc_busy && st_reg.acc_chan == smp.chan) begin
          sum = st_reg.acc + value(smp.code, cc.alternate_resolution_select, st_reg.gcfg.alt_ten, sgn); // R13
          st_next.acc_cnt = st_reg.acc_cnt + 9'h001;
        end else begin
          sum = value(smp.code, cc.alternate_resolution_select, st_reg.gcfg.alt_ten, sgn);
          st_next.acc_cnt = 9'h001;
        end
        st_next.acc = sum;
        st_next.acc_chan = smp.chan;
        st_next.acc_busy = 1'b1;
        if (st_next.acc_cnt == nsamp) begin
          // last sample: publish right aligned
          st_next.acc_busy = 1'b0;
          st_next.results[smp.chan] = fit16(sum, sgn); // R12 R13
          st_next.res.word = fit16(sum, sgn); // R12
          st_next.res.valid = 1'b1;
          st_next.res.chan = smp.chan;
        end
      end else begin
        st_next.results[smp.chan] = place(smp.code, cc.alternate_resolution_select, st_reg.gcfg.alt_ten, sgn,
                                          st_reg.gcfg.left_just); // R06 R07
        st_next.res.word = place(smp.code, cc.alternate_resolution_select, st_reg.gcfg.alt_ten, sgn,
                                 st_reg.gcfg.left_just);
        st_next.res.valid = 1'b1;
        st_next.res.chan = smp.chan;
      end
    end

    // fresh flags: a new result wins over a read in the same cycle
    for (int c = 0; c < SARF_NCHAN; c++) begin
      if (st_next.res.valid && st_next.res.chan == 4'(c)) begin
        st_next.fresh[c] = 1'b1;
      end else if (clr[c]) begin
        st_next.fresh[c] = 1'b0;
      end
    end

    // ready outputs registered from the next state
    st_next.awready = !st_next.aw_got;
    st_next.wready = !st_next.w_got;
    st_next.arready = !st_next.rvalid;
  end

  // reset loads only constants: handshake slots open, all
  // valids low, configuration at its documented defaults.
  // the reset is asynchronous on entry; release is seen on
  // the next clock edge like any other input change.
  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.gcfg <= SARF_GCFG_RST; // R08
      st_reg.ccfg <= {SARF_NCHAN{SARF_CCFG_RST}};
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // no output passes through logic after the register, which
  // keeps the bus timing independent of the decode depth.
  // outputs straight from the state register
  assign res = st_reg.res;
  assign s_awready = st_reg.awready;
  assign s_wready = st_reg.wready;
  assign s_bresp = st_reg.bresp;
  assign s_bvalid = st_reg.bvalid;
  assign s_arready = st_reg.arready;
  assign s_rdata = st_reg.rdata;
  assign s_rresp = st_reg.rresp;
  assign s_rvalid = st_reg.rvalid;

endmodule : sarf_formatter

// [design/sarf_pkg.sv]
// sarf_pkg: constants, register map and carrier types of the result formatter.
// assumes a 125 mhz ref_clk and an axi4-lite master with 32-bit data.
// Functional notes
// [R01] one coding choice for all differential channels
// [R02] one coding choice for all single-ended channels; the code applies se_signed only with the vref negative input
// [R03] 12-bit codes map to documented full-scale words
// [R04] ground-referenced single-ended results always signed
// [R05] below-ground input gives negative result
// [R06] global left or right justification, 16-bit word
// [R07] signed right-justified results are sign extended
// [R08] global averaging sample count, default two
// [R09] one global alternate resolution, 8 or 10
// [R10] per-channel full or alternate resolution
// [R11] external negative input converts as differential
// [R12] averaged results always right aligned
// [R13] accumulated sum truncated to fit 16 bits
// [R14] unused result bits read as zero
package sarf_pkg;

  // channel count: eight sequenced plus the injection channel
  localparam int SARF_NCHAN = 9;

  // register byte offsets
  localparam logic [7:0] SARF_OFS_GLOBAL = 8'h00; // global configuration
  localparam logic [7:0] SARF_OFS_STATUS = 8'h04; // fresh flags and averaging state
  localparam logic [7:0] SARF_OFS_CHCFG = 8'h40; // channel config base, one word each
  localparam logic [7:0] SARF_OFS_RESULT = 8'h80; // result word base, one word each

  // global configuration field positions
  localparam int SARF_GB_DIFF_SIGNED = 0;
  localparam int SARF_GB_SE_SIGNED = 1;
  localparam int SARF_GB_LEFT_JUST = 2;
  localparam int SARF_GB_ALT_TEN = 3;
  localparam int SARF_GB_AVG_LOG = 4; // three bits, samples = 2 << field
  localparam int SARF_GB_SE_NEG = 8; // two bits, single-ended negative input

  // channel configuration field positions
  localparam int SARF_CB_DIFF = 0;
  localparam int SARF_CB_ALT = 1;
  localparam int SARF_CB_AVG = 2;

  // status field positions
  localparam int SARF_SB_AVG_BUSY = 16;

  // axi responses
  localparam logic [1:0] SARF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SARF_RESP_SLVERR = 2'h2;

  // single-ended negative input selection
  typedef enum logic [1:0] {SARF_NEG_VSS, SARF_NEG_VREF, SARF_NEG_EXT} sarf_neg_t;

  // global configuration
  typedef struct packed {
    sarf_neg_t se_neg; // negative input for single-ended channels
    logic [2:0] avg_log; // averaging sample count code
    logic alt_ten; // alternate resolution is 10 bits, else 8
    logic left_just; // left justification, else right
    logic se_signed; // single-ended coding signed
    logic diff_signed; // differential coding signed
  } sarf_gcfg_t;

  // per-channel configuration
  typedef struct packed {
    logic avg; // averaging enabled
    logic alternate_resolution_select; // alternate resolution selected
    logic diff; // differential conversion
  } sarf_ccfg_t;

  // reset values
  localparam sarf_gcfg_t SARF_GCFG_RST = '{se_neg: SARF_NEG_VSS, avg_log: 3'h0, alt_ten: 1'b0,
    left_just: 1'b0, se_signed: 1'b1, diff_signed: 1'b1};
  localparam sarf_ccfg_t SARF_CCFG_RST = '{avg: 1'b0, alternate_resolution_select: 1'b0, diff: 1'b1};

  // converter sample as it arrives
  typedef struct packed {
    logic valid; // one-cycle strobe
    logic [3:0] chan; // channel 0..8
    logic [11:0] code; // offset binary, 12'h800 at zero input
  } sarf_sample_t;

  // formatted result as it leaves
  typedef struct packed {
    logic valid; // one-cycle strobe
    logic [3:0] chan; // channel of the word
    logic [15:0] word; // formatted result word
  } sarf_result_t;

  // the whole register state of the formatter
  typedef struct packed {
    logic aw_got; // write address held
    logic [7:0] aw_addr;
    logic w_got; // write data held
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    sarf_gcfg_t gcfg;
    logic [SARF_NCHAN-1:0][2:0] ccfg;
    logic [SARF_NCHAN-1:0][15:0] results;
    logic [SARF_NCHAN-1:0] fresh; // result not yet read
    logic signed [23:0] acc; // averaging sum
    logic [8:0] acc_cnt; // samples summed so far
    logic [3:0] acc_chan;
    logic acc_busy;
    sarf_result_t res;
  } sarf_state_t;

endpackage : sarf_pkg

// [dv/sarf_conv_model.sv]
// sarf_conv_model: converter front end handing offset-binary samples.
// assumes ref_clk is the converter clock; sends are back to back.
`timescale 1ns/1ps
module sarf_conv_model import sarf_pkg::*; (
  input wire logic ref_clk,
  output sarf_sample_t smp
);
  // idle, nothing offered
  initial smp = '0;
  // n back-to-back samples, code inverted once idle
  task automatic send(input logic [3:0] ch, input logic [11:0] c, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      smp <= '{valid: 1'b1, chan: ch, code: c};
    end
    @(posedge ref_clk);
    smp <= '{valid: 1'b0, chan: ch, code: ~c};
  endtask : send
endmodule : sarf_conv_model

// [dv/sarf_formatter_asserts.sv]
// sarf_formatter_asserts: bus handshake and result timing checks.
// assumes it is bound to sarf_formatter and sees its ports only.
`timescale 1ns/1ps
module sarf_formatter_asserts import sarf_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire sarf_sample_t smp,
  input wire sarf_result_t res,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready
);
  // one clock domain, reset disables all
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // address and data taken at one edge
  sequence s_wr_take;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  // read address taken
  sequence s_rd_take;
    s_arvalid && s_arready;
  endsequence
  AST_WR_RESP: assert property (s_wr_take |-> ##[1:2] s_bvalid)
    else $error("write response missing");
  AST_WR_BUSY: assert property (s_wr_take |=> !s_awready && !s_wready)
    else $error("write slot not closed");
  AST_B_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  AST_RD_RESP: assert property (s_rd_take |=> s_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (s_rvalid |-> !s_arready)
    else $error("read slot open while answering");
  AST_RES_CAUSE: assert property (res.valid |-> $past(smp.valid))
    else $error("result without sample");
  AST_RES_CHAN: assert property (res.valid |-> res.chan == $past(smp.chan))
    else $error("result on wrong channel");
  AST_RES_DROP: assert property (smp.valid && smp.chan > 4'h8 |=> !res.valid)
    else $error("bad channel produced result");
endmodule : sarf_formatter_asserts

bind sarf_formatter sarf_formatter_asserts sarf_formatter_asserts_i (.ref_clk(ref_clk),
  .arst_n(arst_n), .smp(smp), .res(res), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
  .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

// [dv/sarf_formatter_tb_top.sv]
// sarf_formatter_tb_top: register and result format tests.
// assumes the converter model and the bound checker are compiled first.
`timescale 1ns/1ps
module sarf_formatter_tb_top import sarf_pkg::*;;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  sarf_sample_t smp;
  sarf_result_t res;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  int bad_count = 0, num_checks = 0, cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  // 125 mhz clock
  always #4 ref_clk = ~ref_clk;
  sarf_conv_model sarf_conv_model_i (.ref_clk(ref_clk), .smp(smp));
  sarf_formatter sarf_formatter_i (.ref_clk(ref_clk), .arst_n(arst_n), .smp(smp), .res(res),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // closing report
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  // axi4-lite write, each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      s_awvalid <= s_awvalid & ~s_awready;
      s_wvalid <= s_wvalid & ~s_wready;
    end while (!s_bvalid);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  // axi4-lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      s_arvalid <= s_arvalid & ~s_arready;
    end while (!s_rvalid);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  // configure, convert n samples, check pulse and register
  task automatic run(input logic [9:0] g, input logic [3:0] ch, input logic [2:0] cc,
      input int n, input logic [11:0] c, input logic [15:0] e);
    wr(SARF_OFS_GLOBAL, {22'h0, g}, r);
    wr(SARF_OFS_CHCFG + {2'h0, ch, 2'h0}, {29'h0, cc}, r);
    sarf_conv_model_i.send(ch, c, n);
    #1;
    chk({31'h0, res.valid}, 32'h1);
    chk({16'h0, res.word}, {16'h0, e});
    chk({28'h0, res.chan}, {28'h0, ch});
    rd(SARF_OFS_RESULT + {2'h0, ch, 2'h0}, d, r);
    chk(d, {16'h0, e});
  endtask : run
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(SARF_OFS_GLOBAL, d, r);
    chk(d, 32'h3);
    rd(SARF_OFS_CHCFG + 8'h20, d, r);
    chk(d, 32'h1);
    rd(8'h3c, d, r);
    chk({30'h0, r}, {30'h0, SARF_RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h3c, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, SARF_RESP_SLVERR});
    run(10'h003, 4'h0, 3'h1, 1, 12'hfff, 16'h07ff);
    run(10'h003, 4'h0, 3'h1, 1, 12'h800, 16'h0000);
    run(10'h003, 4'h0, 3'h1, 1, 12'h000, 16'hf800);
    run(10'h002, 4'h1, 3'h1, 1, 12'hfff, 16'h0fff);
    run(10'h002, 4'h1, 3'h1, 1, 12'h800, 16'h0800);
    run(10'h000, 4'h2, 3'h0, 1, 12'hfff, 16'h07ff);
    run(10'h000, 4'h2, 3'h0, 1, 12'h7f0, 16'hfff0);
    run(10'h101, 4'h3, 3'h0, 1, 12'h000, 16'h0000);
    run(10'h101, 4'h4, 3'h1, 1, 12'h000, 16'hf800);
    run(10'h202, 4'h5, 3'h0, 1, 12'h800, 16'h0800);
    run(10'h004, 4'h6, 3'h1, 1, 12'hfff, 16'hfff0);
    run(10'h005, 4'h6, 3'h1, 1, 12'h000, 16'h8000);
    run(10'h003, 4'h7, 3'h3, 1, 12'h000, 16'hff80);
    run(10'h002, 4'h7, 3'h3, 1, 12'hfff, 16'h00ff);
    run(10'h00b, 4'h8, 3'h3, 1, 12'h000, 16'hfe00);
    run(10'h00c, 4'h8, 3'h3, 1, 12'hfff, 16'hffc0);
    run(10'h007, 4'h3, 3'h5, 2, 12'h900, 16'h0200);
    run(10'h013, 4'h3, 3'h5, 4, 12'hfff, 16'h1ffc);
    run(10'h073, 4'h4, 3'h5, 256, 12'hfff, 16'h7ff0);
    sarf_conv_model_i.send(4'h9, 12'h123, 1);
    #1;
    chk({31'h0, res.valid}, 32'h0);
    sarf_conv_model_i.send(4'h2, 12'h123, 1);
    rd(SARF_OFS_STATUS, d, r);
    chk(d, 32'h0000_0004);
    sarf_conv_model_i.send(4'h4, 12'h123, 1);
    rd(SARF_OFS_STATUS, d, r);
    chk(d, 32'h0001_0004);
    end_of_test();
  end
endmodule : sarf_formatter_tb_top
